/* logic/phy_dstat_cfg.svh */
// offsets, field positions, reset values and symbol codes of the detailed status logic
`ifndef PHY_DSTAT_CFG_SVH
`define PHY_DSTAT_CFG_SVH

// ----------------------------------------
// register layout
// ----------------------------------------
`define DSTAT_WIDTH        16
`define DSTAT_RESET        16'h0000
`define DSTAT_SIG_LOST     10
`define DSTAT_PLL_ERR      9
`define DSTAT_FALSE_CAR    8
`define DSTAT_BAD_SYM      7
`define DSTAT_HALT_SYM     6
`define DSTAT_PREM_END     5
`define DSTAT_ANEG_DONE    4
`define DSTAT_SIG_DET      3
`define DSTAT_JABBER       2
`define DSTAT_REM_FAULT    1
`define DSTAT_LINK         0
`define DSTAT_EVT_COUNT    6

// ----------------------------------------
// 5-bit line codes
// ----------------------------------------
`define SYM_CODE_IDLE      5'h1F
`define SYM_CODE_J         5'h18
`define SYM_CODE_K         5'h11
`define SYM_CODE_T         5'h0D
`define SYM_CODE_R         5'h07
`define SYM_CODE_HALT      5'h04

`endif

/* logic/phy_dstat_pkg.sv */
// types shared by the detailed status logic
`default_nettype none

package phy_dstat_pkg;

    // ----------------------------------------
    // symbol classes and receive states
    // ----------------------------------------
    typedef enum logic [2:0] {
        SYM_DATA,
        SYM_IDLE,
        SYM_J,
        SYM_K,
        SYM_T,
        SYM_R,
        SYM_HALT,
        SYM_BAD
    } sym_class_t;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_PACKET,
        RX_END
    } rx_state_t;

    // ----------------------------------------
    // event vector, msb first as in the register
    // ----------------------------------------
    typedef struct packed {
        logic sig_lost;
        logic pll_err;
        logic false_car;
        logic bad_sym;
        logic halt_sym;
        logic prem_end;
    } rx_evt_t;

    typedef struct packed {
        logic aneg_done;
        logic sig_det;
        logic jabber;
        logic rem_fault;
        logic link;
    } live_bits_t;

endpackage : phy_dstat_pkg

`default_nettype wire

/* logic/rx_symbol_classifier.sv */
// registered classifier of received 5-bit line symbols
`timescale 1ns/10ps
`default_nettype none
`include "phy_dstat_cfg.svh"

module rx_symbol_classifier
    import phy_dstat_pkg::*;
#(
    parameter int SYM_W = 5
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             sym_valid,
    input  wire logic [SYM_W-1:0] sym_code,
    output logic                  cls_valid_ff,
    output sym_class_t            cls_ff
);

    if (SYM_W != 5) begin : g_bad_width
        $error("symbol width must be 5");
    end

    sym_class_t nxt_cls;

    // ----------------------------------------
    // code decode
    // ----------------------------------------
    always_comb begin
        case (sym_code)
            `SYM_CODE_IDLE: nxt_cls = SYM_IDLE;
            `SYM_CODE_J:    nxt_cls = SYM_J;
            `SYM_CODE_K:    nxt_cls = SYM_K;
            `SYM_CODE_T:    nxt_cls = SYM_T;
            `SYM_CODE_R:    nxt_cls = SYM_R;
            `SYM_CODE_HALT: nxt_cls = SYM_HALT;
            5'h1E, 5'h09, 5'h14, 5'h15,
            5'h0A, 5'h0B, 5'h0E, 5'h0F,
            5'h12, 5'h13, 5'h16, 5'h17,
            5'h1A, 5'h1B, 5'h1C, 5'h1D: nxt_cls = SYM_DATA;
            default:        nxt_cls = SYM_BAD;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cls_valid_ff <= 1'b0;
            cls_ff       <= SYM_IDLE;
        end else begin
            cls_valid_ff <= sym_valid;
            cls_ff       <= nxt_cls;
        end
    end

endmodule : rx_symbol_classifier

`default_nettype wire

/* logic/latch_high_bank.sv */
// bank of latching-high flags, cleared by a read strobe
`timescale 1ns/10ps
`default_nettype none

module latch_high_bank #(
    parameter int N = 6
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [N-1:0] set,
    input  wire logic         clr,
    output logic      [N-1:0] flag_ff
);

    if (N < 1) begin : g_bad_count
        $error("flag count must be at least one");
    end

    // ----------------------------------------
    // one flag per event, set beats clear
    // ----------------------------------------
    for (genvar i = 0; i < N; i++) begin : g_flag
        always_ff @(posedge clk) begin
            if (rst) begin
                flag_ff[i] <= 1'b0;
            end else begin
                flag_ff[i] <= set[i] | (flag_ff[i] & ~clr);
            end
        end
    end

endmodule : latch_high_bank

`default_nettype wire

/* logic/phy_detailed_status.sv */
// detailed status register of the 10/100 PHY: receive event flags and live bits
`timescale 1ns/10ps
`default_nettype none
`include "phy_dstat_cfg.svh"

// Summary of operation
// - receive signal lost in 100 mode sets the signal-lost flag
// - signal present but receive PLL unlocked sets the lock-error flag
// - a frame start that is not J followed by K sets false carrier
// - a bad symbol inside a packet pulses the receive error output
// - the same bad symbol sets the invalid-symbol flag
// - halt symbol in a packet is signalled outward and sets its flag
// - two consecutive idles inside a packet set the premature-end flag
// - all six event flags latch high until read or reset
// - event flags carry no meaning in 10Base-T; events are ignored there
// - negotiation-complete bit reads one only when enabled and finished
// - signal-detect bit shows live line signal presence in 100 mode
// - jabber bit mirrors the basic status jabber bit
// - remote-fault bit mirrors the basic status remote-fault bit
// - link bit mirrors the latching-low basic status link bit
module phy_detailed_status
    import phy_dstat_pkg::*;
#(
    parameter int SYM_W = 5
) (
    input  wire logic             SYS_CLK,
    input  wire logic             RST,
    input  wire logic             MODE_100,
    input  wire logic             AN_ENABLE,
    input  wire logic             AN_DONE,
    input  wire logic             SIG_PRESENT,
    input  wire logic             PLL_LOCKED,
    input  wire logic             SYM_VALID,
    input  wire logic [SYM_W-1:0] SYM_CODE,
    input  wire logic             BASIC_JABBER,
    input  wire logic             BASIC_REMOTE_FAULT,
    input  wire logic             BASIC_LINK,
    input  wire logic             REG_RD,
    output logic      [15:0]      REG_RD_DATA,
    output logic                  RX_ERR,
    output logic                  HALT_SEEN
);

    if (SYM_W != 5) begin : g_bad_width
        $error("symbol width must be 5");
    end

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic       cls_valid;
    sym_class_t cls;

    rx_state_t  state_ff;
    rx_state_t  nxt_state;

    logic       sig_ff;
    logic       prev_idle_ff;
    logic       nxt_prev_idle;

    rx_evt_t    evt;
    rx_evt_t    evt_gated;
    logic [`DSTAT_EVT_COUNT-1:0] flags;

    live_bits_t live;
    logic [15:0] nxt_rd_data;
    logic [15:0] rd_data_ff;

    logic       rx_err_ff;
    logic       nxt_rx_err;
    logic       halt_ff;
    logic       nxt_halt;

    // ----------------------------------------
    // symbol classification
    // ----------------------------------------
    rx_symbol_classifier #(
        .SYM_W        (SYM_W)
    ) u_classifier (
        .clk          (SYS_CLK),
        .rst          (RST),
        .sym_valid    (SYM_VALID),
        .sym_code     (SYM_CODE),
        .cls_valid_ff (cls_valid),
        .cls_ff       (cls)
    );

    // ----------------------------------------
    // signal presence history
    // ----------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            sig_ff <= 1'b0;
        end else begin
            sig_ff <= SIG_PRESENT;
        end
    end

    // ----------------------------------------
    // receive stream tracking
    // ----------------------------------------
    always_comb begin
        nxt_state     = state_ff;
        nxt_prev_idle = prev_idle_ff;
        evt.sig_lost  = sig_ff & ~SIG_PRESENT;
        evt.pll_err   = SIG_PRESENT & ~PLL_LOCKED;
        evt.false_car = 1'b0;
        evt.bad_sym   = 1'b0;
        evt.halt_sym  = 1'b0;
        evt.prem_end  = 1'b0;
        nxt_rx_err    = 1'b0;
        nxt_halt      = 1'b0;
        if (!SIG_PRESENT) begin
            nxt_state     = RX_IDLE;
            nxt_prev_idle = 1'b0;
        end else if (cls_valid) begin
            case (state_ff)
                RX_IDLE: begin
                    if (cls == SYM_J) begin
                        nxt_state = RX_START;
                    end else if (cls != SYM_IDLE) begin
                        evt.false_car = 1'b1;
                    end
                end
                RX_START: begin
                    if (cls == SYM_K) begin
                        nxt_state     = RX_PACKET;
                        nxt_prev_idle = 1'b0;
                    end else begin
                        evt.false_car = 1'b1;
                        nxt_state     = RX_IDLE;
                    end
                end
                RX_PACKET: begin
                    nxt_prev_idle = (cls == SYM_IDLE);
                    case (cls)
                        SYM_IDLE: begin
                            if (prev_idle_ff) begin
                                evt.prem_end = 1'b1;
                                nxt_rx_err   = 1'b1;
                                nxt_state    = RX_IDLE;
                            end
                        end
                        SYM_T: begin
                            nxt_state = RX_END;
                        end
                        SYM_HALT: begin
                            evt.halt_sym = 1'b1;
                            nxt_halt     = 1'b1;
                            nxt_rx_err   = 1'b1;
                        end
                        SYM_DATA: begin
                            nxt_state = RX_PACKET;
                        end
                        default: begin
                            evt.bad_sym = 1'b1;
                            nxt_rx_err  = 1'b1;
                        end
                    endcase
                end
                RX_END: begin
                    nxt_state     = RX_IDLE;
                    nxt_prev_idle = 1'b0;
                end
                default: begin
                    nxt_state = RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state_ff     <= RX_IDLE;
            prev_idle_ff <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            prev_idle_ff <= nxt_prev_idle;
        end
    end

    // ----------------------------------------
    // indications toward the mac
    // ----------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            rx_err_ff <= 1'b0;
            halt_ff   <= 1'b0;
        end else begin
            rx_err_ff <= nxt_rx_err & MODE_100;
            halt_ff   <= nxt_halt & MODE_100;
        end
    end

    assign RX_ERR    = rx_err_ff;
    assign HALT_SEEN = halt_ff;

    // ----------------------------------------
    // event gating by mode
    // ----------------------------------------

    // no event counts outside 100Base-TX
    assign evt_gated = MODE_100 ? evt : '0;

    // ----------------------------------------
    // latched event flags
    // ----------------------------------------
    latch_high_bank #(
        .N       (`DSTAT_EVT_COUNT)
    ) u_flags (
        .clk     (SYS_CLK),
        .rst     (RST),
        .set     (evt_gated),
        .clr     (REG_RD),
        .flag_ff (flags)
    );

    // ----------------------------------------
    // live and mirrored bits
    // ----------------------------------------
    assign live.aneg_done = AN_ENABLE & AN_DONE;
    assign live.sig_det   = MODE_100 & SIG_PRESENT;
    assign live.jabber    = BASIC_JABBER;
    assign live.rem_fault = BASIC_REMOTE_FAULT;
    assign live.link      = BASIC_LINK;

    // ----------------------------------------
    // register read
    // ----------------------------------------
    always_comb begin
        nxt_rd_data = `DSTAT_RESET;
        nxt_rd_data[`DSTAT_SIG_LOST:`DSTAT_PREM_END] = flags;
        nxt_rd_data[`DSTAT_ANEG_DONE]                = live.aneg_done;
        nxt_rd_data[`DSTAT_SIG_DET]                  = live.sig_det;
        nxt_rd_data[`DSTAT_JABBER]                   = live.jabber;
        nxt_rd_data[`DSTAT_REM_FAULT]                = live.rem_fault;
        nxt_rd_data[`DSTAT_LINK]                     = live.link;
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            rd_data_ff <= `DSTAT_RESET;
        end else if (REG_RD) begin
            rd_data_ff <= nxt_rd_data;
        end
    end

    assign REG_RD_DATA = rd_data_ff;

endmodule : phy_detailed_status

`default_nettype wire

/* tb/mgmt_station_model.sv */
// management station model issuing reads of the detailed status register
`timescale 1ns/10ps
`default_nettype none

module mgmt_station_model (
    input  wire logic        clk,
    output logic             rd_strobe,
    input  wire logic [15:0] rd_data
);
    initial rd_strobe = 1'b0;

    // one read: strobe held to the taking edge, answer taken after it
    task automatic rd(output logic [15:0] v);
        rd_strobe = 1'b1;
        @(posedge clk);
        #1;
        rd_strobe = 1'b0;
        v = rd_data;
        @(posedge clk);
        #1;
    endtask : rd
endmodule : mgmt_station_model

`default_nettype wire

/* tb/phy_detailed_status_properties.sv */
// port assertions of the detailed status register
`timescale 1ns/10ps
`default_nettype none
`include "phy_dstat_cfg.svh"

module phy_detailed_status_properties #(
    parameter int SYM_W = 5
) (
    input wire logic             SYS_CLK,
    input wire logic             RST,
    input wire logic             MODE_100,
    input wire logic             AN_ENABLE,
    input wire logic             AN_DONE,
    input wire logic             SIG_PRESENT,
    input wire logic             SYM_VALID,
    input wire logic [SYM_W-1:0] SYM_CODE,
    input wire logic             BASIC_JABBER,
    input wire logic             BASIC_REMOTE_FAULT,
    input wire logic             BASIC_LINK,
    input wire logic             REG_RD,
    input wire logic [15:0]      REG_RD_DATA,
    input wire logic             RX_ERR,
    input wire logic             HALT_SEEN
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);

    a_upper_zero: assert property (REG_RD_DATA[15:11] == 5'h00)
        else $error("upper bits not zero");
    a_aneg_bit: assert property (REG_RD |=> REG_RD_DATA[4] == ($past(AN_ENABLE) && $past(AN_DONE)))
        else $error("aneg bit wrong");
    a_sigdet_bit: assert property (REG_RD |=> REG_RD_DATA[3] == ($past(MODE_100) && $past(SIG_PRESENT)))
        else $error("signal detect bit wrong");
    a_mirror_bits: assert property (REG_RD |=> REG_RD_DATA[2:0] ==
        {$past(BASIC_JABBER), $past(BASIC_REMOTE_FAULT), $past(BASIC_LINK)})
        else $error("mirror bits wrong");
    a_data_holds: assert property (!REG_RD |=> $stable(REG_RD_DATA))
        else $error("read data moved");
    a_halt_cause: assert property (HALT_SEEN |-> $past(SYM_VALID, 2) && $past(SYM_CODE, 2) == `SYM_CODE_HALT)
        else $error("halt pulse without halt symbol");
    a_halt_err: assert property (HALT_SEEN |-> RX_ERR)
        else $error("halt without receive error");
    a_err_cause: assert property (RX_ERR |-> $past(SYM_VALID, 2))
        else $error("receive error without symbol");
    a_quiet_slow: assert property (!MODE_100 [*3] |-> !RX_ERR && !HALT_SEEN)
        else $error("event in slow mode");
endmodule : phy_detailed_status_properties

bind phy_detailed_status phy_detailed_status_properties #(.SYM_W(SYM_W)) props_u (
    .SYS_CLK(SYS_CLK), .RST(RST), .MODE_100(MODE_100), .AN_ENABLE(AN_ENABLE),
    .AN_DONE(AN_DONE), .SIG_PRESENT(SIG_PRESENT), .SYM_VALID(SYM_VALID), .SYM_CODE(SYM_CODE),
    .BASIC_JABBER(BASIC_JABBER), .BASIC_REMOTE_FAULT(BASIC_REMOTE_FAULT),
    .BASIC_LINK(BASIC_LINK), .REG_RD(REG_RD), .REG_RD_DATA(REG_RD_DATA),
    .RX_ERR(RX_ERR), .HALT_SEEN(HALT_SEEN));

`default_nettype wire

/* tb/phy_detailed_status_test.sv */
// self-checking bench of the detailed status register
`timescale 1ns/10ps
`default_nettype none
`include "phy_dstat_cfg.svh"

`define CHK(nm, e, g) begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
        fails++; \
        $display("[FAIL] %s exp %h got %h", nm, e, g); \
    end \
end

module phy_detailed_status_test;
    import phy_dstat_pkg::*;
    logic clk, rst, mode, an_en, an_done, sig, pll, sv, jab, rf, lnk, rd, err, halt;
    logic [4:0]  sc;
    logic [15:0] rdata, v;
    int          fails, cmp_count;
    int          err_n, halt_n;
    localparam logic [15:0] LIVE = 16'h0001 << `DSTAT_SIG_DET;
    localparam logic [4:0] I = `SYM_CODE_IDLE, J = `SYM_CODE_J, K = `SYM_CODE_K;
    localparam logic [4:0] T = `SYM_CODE_T, R = `SYM_CODE_R, D = 5'h1E;
    localparam logic [4:0] H = `SYM_CODE_HALT, X = 5'h00;

    phy_detailed_status #(.SYM_W(5)) dut_u (
        .SYS_CLK(clk), .RST(rst), .MODE_100(mode), .AN_ENABLE(an_en), .AN_DONE(an_done),
        .SIG_PRESENT(sig), .PLL_LOCKED(pll), .SYM_VALID(sv), .SYM_CODE(sc),
        .BASIC_JABBER(jab), .BASIC_REMOTE_FAULT(rf), .BASIC_LINK(lnk), .REG_RD(rd),
        .REG_RD_DATA(rdata), .RX_ERR(err), .HALT_SEEN(halt));
    mgmt_station_model mgmt_u (.clk(clk), .rd_strobe(rd), .rd_data(rdata));

    // one-cycle pulses toward the mac, counted mid-cycle
    always @(negedge clk) begin
        if (err === 1'b1) begin
            err_n++;
        end
        if (halt === 1'b1) begin
            halt_n++;
        end
    end

    function automatic logic [15:0] fb(input int p);
        return 16'h0001 << p;
    endfunction : fb

    // send symbols, let flags settle, read the event, read again after clear
    task automatic run(input logic [4:0] s[8], input int n, input logic [15:0] e,
                       input logic [15:0] lv, input int ne, input int nh);
        int e0;
        int h0;
        e0 = err_n;
        h0 = halt_n;
        for (int i = 0; i < n; i++) begin
            sv = 1'b1;
            sc = s[i];
            @(posedge clk);
            #1;
        end
        sv = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        mgmt_u.rd(v);
        `CHK("event read", e, v)
        mgmt_u.rd(v);
        `CHK("after clear", lv, v)
        `CHK("rx error pulses", ne, err_n - e0)
        `CHK("halt pulses", nh, halt_n - h0)
    endtask : run

    task print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        #(5000 * 100);
        fails++;
        print_verdict();
    end

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        {rst, mode, sig, pll, an_en} = 5'h1F;
        {an_done, sv, jab, rf, lnk, sc} = 10'h000;
        fails = 0;
        cmp_count = 0;
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        mgmt_u.rd(v);
        `CHK("reset read", LIVE, v)
        run('{I, J, K, D, H, D, T, R}, 8, LIVE | fb(`DSTAT_HALT_SYM), LIVE, 1, 1);
        run('{I, J, K, D, X, D, T, R}, 8, LIVE | fb(`DSTAT_BAD_SYM), LIVE, 1, 0);
        run('{J, K, D, I, I, I, I, I}, 5, LIVE | fb(`DSTAT_PREM_END), LIVE, 1, 0);
        run('{I, J, D, I, I, I, I, I}, 4, LIVE | fb(`DSTAT_FALSE_CAR), LIVE, 0, 0);
        run('{D, I, I, I, I, I, I, I}, 2, LIVE | fb(`DSTAT_FALSE_CAR), LIVE, 0, 0);
        pll = 1'b0;
        @(posedge clk);
        #1;
        pll = 1'b1;
        run('{I, I, I, I, I, I, I, I}, 0, LIVE | fb(`DSTAT_PLL_ERR), LIVE, 0, 0);
        sig = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        sig = 1'b1;
        run('{I, I, I, I, I, I, I, I}, 0, LIVE | fb(`DSTAT_SIG_LOST), LIVE, 0, 0);
        pll = 1'b0;
        fork
            mgmt_u.rd(v);
            begin
                @(posedge clk);
                #1;
                pll = 1'b1;
            end
        join
        `CHK("coinciding read", LIVE, v)
        run('{I, I, I, I, I, I, I, I}, 0, LIVE | fb(`DSTAT_PLL_ERR), LIVE, 0, 0);
        pll = 1'b0;
        @(posedge clk);
        #1;
        {pll, rst} = 2'h3;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        mgmt_u.rd(v);
        `CHK("read after reset", LIVE, v)
        mode = 1'b0;
        pll = 1'b0;
        @(posedge clk);
        #1;
        pll = 1'b1;
        run('{I, J, K, D, X, H, T, R}, 8, 16'h0000, 16'h0000, 0, 0);
        mode = 1'b1;
        {an_done, jab, rf, lnk} = 4'hF;
        mgmt_u.rd(v);
        `CHK("live bits", 16'h001F, v)
        an_en = 1'b0;
        mgmt_u.rd(v);
        `CHK("aneg disabled", 16'h000F, v)
        print_verdict();
    end
endmodule : phy_detailed_status_test

`default_nettype wire
